// ### hw/mosc_ctrl.sv
// main oscillator control: code, trims, spread, clock source choices
// assumes a same-clock register port and a same-clock factory trim source;
// the fabric spread input is asynchronous and is synchronised here
//
// What this block does
// - Oscillator runs 3 to 48 MHz, 1 MHz steps.
// - Code maps to MHz; unlisted codes undefined.
// - Reset gives 24 MHz; boot loads factory trims.
// - Shape: off, triangle, random, fabric driven.
// - Limit sets counter maximum and triangle period.
// - Random shape uses an lfsr sequence.
// - Fabric shape follows the fabric input signal.
// - Depth codes give 1, 2, 4 percent.
// - Spread is downspread only.
// - Spread steps at peripheral clock 0 rate.
// - Separate 36 MHz output only for flash programming.
// - High clock from main oscillator or pin.
// - Low clock always from low speed oscillator.
// - Select 0 main, 1 pin, others reserved.
`timescale 1ns/1ps
`default_nettype none
module mosc_ctrl
  import mosc_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  // register port
  input  var  mosc_bus_s         bus,
  output logic [DATA_W-1:0]      reg_rdata,
  // factory trim fetch at boot
  output logic                   boot_req,
  input  var  mosc_trim_s        factory_trim,
  input  wire logic              factory_valid,
  // spread pacing and fabric pattern
  input  wire logic              periph_clk0_en,
  input  wire logic              spread_fabric_in,
  // flash programming clock request
  input  wire logic              flash_prog_req,
  // oscillator controls
  output logic [CODE_W-1:0]      osc_code,
  output mosc_trim_s             osc_trim,
  output logic [DOWN_W-1:0]      spread_down,
  output logic                   prog_clk_en,
  // clock source choices
  output logic                   hf_src_ext,
  output logic                   lf_src_low_speed
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    mosc_boot_e        boot;
    logic [CODE_W-1:0] code;
    mosc_trim_s        trim;
    mosc_spread_cfg_s  spread;
    logic [SEL_W-1:0]  hf_sel;
    logic              bad_code;
    logic [TMR_W-1:0]  settle;
    logic [DATA_W-1:0] rdata;
    logic              prog_en;
    logic              fab_meta;
    logic              fab_sync;
  } mosc_ctrl_state_s;

  localparam mosc_ctrl_state_s STATE_RST = '{
    boot:     BOOT_FETCH,
    code:     CODE_RST,
    trim:     '{fine: TRIM_RST, ref_a: TRIM_RST, ref_b: TRIM_RST},
    spread:   '{shape: SHAPE_OFF, depth: DEPTH_1, limit: LIMIT_RST},
    hf_sel:   HF_SEL_MAIN,
    bad_code: 1'b0,
    settle:   '0,
    rdata:    '0,
    prog_en:  1'b0,
    fab_meta: 1'b0,
    fab_sync: 1'b0
  };

  localparam logic [TMR_W-1:0] RAISE_TMR = TMR_W'(RAISE_WAIT_CYC);
  localparam logic [TMR_W-1:0] LOWER_TMR = TMR_W'(LOWER_WAIT_CYC);

  mosc_ctrl_state_s  s_q, s_d;
  logic [CODE_W-1:0] new_code;
  logic [CODE_W-1:0] new_mhz;
  logic [CODE_W-1:0] cur_mhz;
  logic              wr_code;
  logic              wr_trim;
  logic [LIM_W-1:0]  ss_count;
  logic [DATA_W-1:0] status_word;

  // ****************************************
  // write decode helpers
  // ****************************************
  // decode of the code port is shared by the update and the checks
  assign new_code = bus.wdata[CODE_W-1:0];
  assign new_mhz  = mosc_mhz_of(new_code);
  assign cur_mhz  = mosc_mhz_of(s_q.code);
  assign wr_code  = bus.wr && bus.addr == OFF_CODE;
  assign wr_trim  = bus.wr && (bus.addr == OFF_FINE || bus.addr == OFF_REFA
                               || bus.addr == OFF_REFB);

  // status word: live frequency, flags and spread position
  always_comb begin
    status_word = '0;
    status_word[ST_BAD_BIT-1:0]             = cur_mhz;
    status_word[ST_BAD_BIT]                 = s_q.bad_code;
    status_word[ST_BUSY_BIT]                = s_q.settle != '0;
    status_word[ST_BOOT_BIT]                = s_q.boot == BOOT_DONE;
    status_word[ST_COUNT_LSB +: LIM_W]      = ss_count;
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d = s_q;

    // fabric pattern crosses in through two flops
    s_d.fab_meta = spread_fabric_in;
    s_d.fab_sync = s_q.fab_meta;

    // dedicated programming clock; never offered to the source mux
    s_d.prog_en = flash_prog_req;

    // settle timer counts down; a new load below takes over
    if (s_q.settle != '0) s_d.settle = s_q.settle - 1'b1;

    // register writes
    if (bus.wr) begin
      unique case (bus.addr)
        OFF_CODE: begin
          if (new_mhz != '0) begin
            s_d.code     = new_code;
            s_d.bad_code = 1'b0;
            // lowering: trims may follow only after a short wait
            if (new_mhz < cur_mhz) s_d.settle = LOWER_TMR;
          end else begin
            s_d.bad_code = 1'b1;
          end
        end
        OFF_FINE: begin
          s_d.trim.fine = bus.wdata[TRIM_W-1:0];
          s_d.settle    = RAISE_TMR;
        end
        OFF_REFA: begin
          s_d.trim.ref_a = bus.wdata[TRIM_W-1:0];
          s_d.settle     = RAISE_TMR;
        end
        OFF_REFB: begin
          s_d.trim.ref_b = bus.wdata[TRIM_W-1:0];
          s_d.settle     = RAISE_TMR;
        end
        OFF_SPREAD: begin
          s_d.spread.shape = mosc_shape_e'(bus.wdata[SS_SHAPE_LSB +: 2]);
          s_d.spread.depth = mosc_depth_e'(bus.wdata[SS_DEPTH_LSB +: 2]);
          s_d.spread.limit = bus.wdata[SS_LIMIT_LSB +: LIM_W];
        end
        OFF_SELECT: begin
          // reserved source codes are refused, the old source stays
          if (bus.wdata[SEL_W-1:0] == HF_SEL_MAIN
              || bus.wdata[SEL_W-1:0] == HF_SEL_EXT)
            s_d.hf_sel = bus.wdata[SEL_W-1:0];
        end
        default: ;
      endcase
    end

    // boot: factory trims for the reset frequency win over any early write
    unique case (s_q.boot)
      BOOT_FETCH: begin
        if (factory_valid) begin
          s_d.trim = factory_trim;
          s_d.boot = BOOT_DONE;
        end
      end
      BOOT_DONE: ;
    endcase

    // read data stand for exactly one cycle after the strobe
    s_d.rdata = '0;
    if (bus.rd) begin
      unique case (bus.addr)
        OFF_CODE:   s_d.rdata = DATA_W'(s_q.code);
        OFF_FINE:   s_d.rdata = DATA_W'(s_q.trim.fine);
        OFF_REFA:   s_d.rdata = DATA_W'(s_q.trim.ref_a);
        OFF_REFB:   s_d.rdata = DATA_W'(s_q.trim.ref_b);
        OFF_SPREAD: begin
          s_d.rdata[SS_SHAPE_LSB +: 2]     = s_q.spread.shape;
          s_d.rdata[SS_DEPTH_LSB +: 2]     = s_q.spread.depth;
          s_d.rdata[SS_LIMIT_LSB +: LIM_W] = s_q.spread.limit;
        end
        OFF_SELECT: s_d.rdata = DATA_W'(s_q.hf_sel);
        OFF_STATUS: s_d.rdata = status_word;
        default:    s_d.rdata = '0;
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // spread generator
  // ****************************************
  // stepped by the peripheral clock 0 enable, not by its own clock
  mosc_spread u_spread (
    .sys_clk      (sys_clk),
    .nrst         (nrst),
    .step_en      (periph_clk0_en),
    .cfg          (s_q.spread),
    .fabric_level (s_q.fab_sync),
    .count        (ss_count),
    .down         (spread_down)
  );

  // ****************************************
  // outputs
  // ****************************************
  assign reg_rdata        = s_q.rdata;
  assign boot_req         = s_q.boot == BOOT_FETCH;
  assign osc_code         = s_q.code;
  assign osc_trim         = s_q.trim;
  assign prog_clk_en      = s_q.prog_en;
  assign hf_src_ext       = s_q.hf_sel == HF_SEL_EXT;
  assign lf_src_low_speed = 1'b1;

  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  property p_rst_code;
    !$past(nrst) |-> osc_code == CODE_RST && boot_req;
  endproperty
  a_rst_code: assert property (p_rst_code) else $error("reset code not 24 MHz");

  property p_boot_load;
    boot_req && factory_valid |=> osc_trim == $past(factory_trim) && !boot_req;
  endproperty
  a_boot_load: assert property (p_boot_load) else $error("factory trim not loaded");

  property p_code_ok;
    // flag cleared in the same cycle; a later refused write may set it again
    wr_code && new_mhz != '0 |=> osc_code == $past(new_code) && !s_q.bad_code;
  endproperty
  a_code_ok: assert property (p_code_ok) else $error("valid code not taken");

  property p_code_bad;
    wr_code && new_mhz == '0 |=> $stable(osc_code) && s_q.bad_code;
  endproperty
  a_code_bad: assert property (p_code_bad) else $error("undefined code taken");

  property p_raise_wait;
    wr_trim |=> (s_q.settle != '0)[*8];
  endproperty
  a_raise_wait: assert property (p_raise_wait) else $error("trim wait too short");

  property p_lower_wait;
    wr_code && new_mhz != '0 && new_mhz < cur_mhz && !bus.rd
      |=> s_q.settle == LOWER_TMR;
  endproperty
  a_lower_wait: assert property (p_lower_wait) else $error("lower wait not loaded");

  property p_sel_rsvd;
    bus.wr && bus.addr == OFF_SELECT && bus.wdata[SEL_W-1:0] > HF_SEL_EXT
      |=> $stable(hf_src_ext);
  endproperty
  a_sel_rsvd: assert property (p_sel_rsvd) else $error("reserved source taken");

  property p_sel_ext;
    bus.wr && bus.addr == OFF_SELECT && bus.wdata[SEL_W-1:0] == HF_SEL_EXT
      |=> hf_src_ext;
  endproperty
  a_sel_ext: assert property (p_sel_ext) else $error("pin clock not selected");

  property p_lf_src;
    1'b1 |-> lf_src_low_speed;
  endproperty
  a_lf_src: assert property (p_lf_src) else $error("low clock source lost");

  property p_prog;
    flash_prog_req |=> prog_clk_en;
  endproperty
  a_prog: assert property (p_prog) else $error("programming clock not enabled");

  property p_rd_code;
    bus.rd && bus.addr == OFF_CODE |=> reg_rdata == DATA_W'($past(osc_code));
  endproperty
  a_rd_code: assert property (p_rd_code) else $error("code readback wrong");

  property p_rd_idle;
    !bus.rd |=> reg_rdata == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");

  property p_settle_load;
    wr_trim |=> s_q.settle == RAISE_TMR;
  endproperty
  a_settle_load: assert property (p_settle_load) else $error("trim wait not loaded");

  property p_settle_dec;
    s_q.settle != '0 && !bus.wr |=> s_q.settle == $past(s_q.settle) - 1'b1;
  endproperty
  a_settle_dec: assert property (p_settle_dec) else $error("settle timer stuck");

  property p_boot_once;
    !boot_req && factory_valid && !wr_trim |=> $stable(osc_trim);
  endproperty
  a_boot_once: assert property (p_boot_once) else $error("factory trim after boot");

  property p_sel_main;
    bus.wr && bus.addr == OFF_SELECT && bus.wdata[SEL_W-1:0] == HF_SEL_MAIN
      |=> !hf_src_ext;
  endproperty
  a_sel_main: assert property (p_sel_main) else $error("main oscillator not selected");

  property p_trim_wr;
    bus.wr && bus.addr == OFF_REFA && !(boot_req && factory_valid)
      |=> osc_trim.ref_a == $past(bus.wdata[TRIM_W-1:0]);
  endproperty
  a_trim_wr: assert property (p_trim_wr) else $error("reference trim not taken");

  property p_rd_status;
    bus.rd && bus.addr == OFF_STATUS |=> reg_rdata[ST_BAD_BIT-1:0] == $past(cur_mhz);
  endproperty
  a_rd_status: assert property (p_rd_status) else $error("status frequency wrong");

  property p_rd_sel;
    bus.rd && bus.addr == OFF_SELECT |=> reg_rdata[0] == $past(hf_src_ext);
  endproperty
  a_rd_sel: assert property (p_rd_sel) else $error("source readback wrong");

  property p_mhz_valid;
    1'b1 |-> cur_mhz != '0;
  endproperty
  a_mhz_valid: assert property (p_mhz_valid) else $error("code has no frequency");

endmodule : mosc_ctrl
`default_nettype wire

// ### hw/mosc_pkg.sv
// main oscillator control: shared constants, types and decode functions
// assumes one 100 MHz system clock and a word-aligned register port
package mosc_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CODE_W = 6;
  localparam int TRIM_W = 8;
  localparam int LIM_W  = 8;
  localparam int UNIT_W = 9;
  localparam int DOWN_W = 9;
  localparam int PROD_W = LIM_W + DOWN_W;
  localparam int SEL_W  = 3;
  localparam int TMR_W  = 10;
  localparam int LFSR_W = 16;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [ADDR_W-1:0] OFF_CODE   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_FINE   = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_REFA   = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_REFB   = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_SPREAD = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_SELECT = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h18;

  // field positions
  localparam int SS_SHAPE_LSB = 0;
  localparam int SS_DEPTH_LSB = 2;
  localparam int SS_LIMIT_LSB = 8;
  localparam int ST_BAD_BIT   = 6;
  localparam int ST_BUSY_BIT  = 7;
  localparam int ST_BOOT_BIT  = 8;
  localparam int ST_COUNT_LSB = 16;

  // reset values
  localparam logic [CODE_W-1:0] CODE_RST  = 6'h19;
  localparam logic [TRIM_W-1:0] TRIM_RST  = 8'h00;
  localparam logic [LIM_W-1:0]  LIMIT_RST = 8'h40;

  // high-frequency source select codes
  localparam logic [SEL_W-1:0] HF_SEL_MAIN = 3'h0;
  localparam logic [SEL_W-1:0] HF_SEL_EXT  = 3'h1;

  // ****************************************
  // frequency code bands: mhz = code - sub
  // ****************************************
  localparam logic [CODE_W-1:0] B0_LO = 6'h03;
  localparam logic [CODE_W-1:0] B0_HI = 6'h0c;
  localparam logic [CODE_W-1:0] B1_LO = 6'h0e;
  localparam logic [CODE_W-1:0] B1_HI = 6'h19;
  localparam logic [CODE_W-1:0] B2_LO = 6'h1b;
  localparam logic [CODE_W-1:0] B2_HI = 6'h23;
  localparam logic [CODE_W-1:0] B3_LO = 6'h25;
  localparam logic [CODE_W-1:0] B3_HI = 6'h2b;
  localparam logic [CODE_W-1:0] B4_LO = 6'h2e;
  localparam logic [CODE_W-1:0] B4_HI = 6'h35;
  localparam logic [CODE_W-1:0] B1_SUB = 6'h01;
  localparam logic [CODE_W-1:0] B2_SUB = 6'h02;
  localparam logic [CODE_W-1:0] B3_SUB = 6'h03;
  localparam logic [CODE_W-1:0] B4_SUB = 6'h05;

  // ****************************************
  // timing
  // ****************************************
  localparam int SYS_CLK_MHZ    = 100;
  localparam int RAISE_WAIT_NS  = 5000;
  localparam int RAISE_WAIT_CYC = (RAISE_WAIT_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int LOWER_WAIT_CYC = 5;

  // spread depth in hundredths of a percent
  localparam logic [UNIT_W-1:0] DEPTH_1PCT = 9'h064;
  localparam logic [UNIT_W-1:0] DEPTH_2PCT = 9'h0c8;
  localparam logic [UNIT_W-1:0] DEPTH_4PCT = 9'h190;

  localparam logic [LFSR_W-1:0] LFSR_SEED = 16'hace1;
  localparam logic [LFSR_W-1:0] LFSR_TAPS = 16'hb400;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    SHAPE_OFF    = 2'b00,
    SHAPE_TRI    = 2'b01,
    SHAPE_RAND   = 2'b10,
    SHAPE_FABRIC = 2'b11
  } mosc_shape_e;

  typedef enum logic [1:0] {
    DEPTH_1 = 2'b00,
    DEPTH_2 = 2'b01,
    DEPTH_4 = 2'b10,
    DEPTH_R = 2'b11
  } mosc_depth_e;

  typedef enum logic {
    BOOT_FETCH = 1'b0,
    BOOT_DONE  = 1'b1
  } mosc_boot_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } mosc_bus_s;

  typedef struct packed {
    logic [TRIM_W-1:0] fine;
    logic [TRIM_W-1:0] ref_a;
    logic [TRIM_W-1:0] ref_b;
  } mosc_trim_s;

  typedef struct packed {
    mosc_shape_e      shape;
    mosc_depth_e      depth;
    logic [LIM_W-1:0] limit;
  } mosc_spread_cfg_s;

  // ****************************************
  // functions
  // ****************************************
  // code to MHz; zero marks a code with no frequency
  function automatic logic [CODE_W-1:0] mosc_mhz_of(input logic [CODE_W-1:0] c);
    logic [CODE_W-1:0] m;
    m = '0;
    if (c >= B0_LO && c <= B0_HI) m = c;
    else if (c >= B1_LO && c <= B1_HI) m = c - B1_SUB;
    else if (c >= B2_LO && c <= B2_HI) m = c - B2_SUB;
    else if (c >= B3_LO && c <= B3_HI) m = c - B3_SUB;
    else if (c >= B4_LO && c <= B4_HI) m = c - B4_SUB;
    return m;
  endfunction : mosc_mhz_of

  // reserved depth falls back to the smallest spread
  function automatic logic [UNIT_W-1:0] mosc_depth_units(input mosc_depth_e d);
    logic [UNIT_W-1:0] u;
    u = DEPTH_1PCT;
    if (d == DEPTH_2) u = DEPTH_2PCT;
    else if (d == DEPTH_4) u = DEPTH_4PCT;
    return u;
  endfunction : mosc_depth_units

endpackage : mosc_pkg

// ### hw/mosc_spread.sv
// spread-spectrum counter: triangle, lfsr or fabric-driven, downspread only
// assumes step_en is a one-cycle enable from the peripheral divider
`timescale 1ns/1ps
`default_nettype none
module mosc_spread
  import mosc_pkg::*;
(
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  // pacing and setup
  input  wire logic             step_en,
  input  var  mosc_spread_cfg_s cfg,
  input  wire logic             fabric_level,
  // modulation out
  output logic [LIM_W-1:0]      count,
  output logic [DOWN_W-1:0]     down
);

  typedef struct packed {
    logic [LIM_W-1:0]  count;
    logic              dir_up;
    logic [LFSR_W-1:0] lfsr;
    logic [DOWN_W-1:0] down;
  } mosc_spread_state_s;

  mosc_spread_state_s s_q, s_d;
  logic [UNIT_W-1:0]  units;
  logic [PROD_W-1:0]  prod;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d   = s_q;
    units = mosc_depth_units(cfg.depth);
    // count is at most 255, so down = count * depth / 256 stays below the depth
    prod  = PROD_W'(s_q.count) * PROD_W'(units);
    s_d.down = prod[LIM_W +: DOWN_W];
    if (step_en) begin
      unique case (cfg.shape)
        SHAPE_OFF: begin
          s_d.count  = '0;
          s_d.dir_up = 1'b1;
        end
        SHAPE_TRI: begin
          if (s_q.count > cfg.limit) s_d.count = cfg.limit;
          else if (s_q.dir_up) begin
            if (s_q.count < cfg.limit) s_d.count = s_q.count + 1'b1;
            else s_d.dir_up = 1'b0;
          end else begin
            if (s_q.count != '0) s_d.count = s_q.count - 1'b1;
            else s_d.dir_up = 1'b1;
          end
        end
        SHAPE_RAND: begin
          s_d.lfsr  = {s_q.lfsr[LFSR_W-2:0], ^(s_q.lfsr & LFSR_TAPS)};
          s_d.count = s_q.lfsr[LIM_W-1:0] & cfg.limit;
        end
        SHAPE_FABRIC: begin
          // fabric level steers the count up or down
          if (s_q.count > cfg.limit) s_d.count = cfg.limit;
          else if (fabric_level && s_q.count < cfg.limit)
            s_d.count = s_q.count + 1'b1;
          else if (!fabric_level && s_q.count != '0)
            s_d.count = s_q.count - 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      s_q <= '{count: '0, dir_up: 1'b1, lfsr: LFSR_SEED, down: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign count = s_q.count;
  assign down  = s_q.down;

  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  property p_off_zero;
    step_en && cfg.shape == SHAPE_OFF |=> count == '0 ##1 down == '0;
  endproperty
  a_off_zero: assert property (p_off_zero) else $error("spread not zero when off");

  property p_down_bound;
    1'b1 |=> down < $past(units);
  endproperty
  a_down_bound: assert property (p_down_bound) else $error("spread above depth");

  property p_limit;
    step_en |=> count <= $past(cfg.limit);
  endproperty
  a_limit: assert property (p_limit) else $error("spread count over limit");

  property p_tri_up;
    step_en && cfg.shape == SHAPE_TRI && s_q.dir_up && count < cfg.limit
      |=> count == $past(count) + 1'b1;
  endproperty
  a_tri_up: assert property (p_tri_up) else $error("triangle did not climb");

  property p_hold;
    !step_en |=> $stable(count);
  endproperty
  a_hold: assert property (p_hold) else $error("spread moved without step");

endmodule : mosc_spread
`default_nettype wire

// ### sim/mosc_ctrl_tb.sv
// bench for mosc_ctrl: register tasks, boot load, code, select, spread shapes
// assumes the design package and both design files are compiled first
`timescale 1ns/1ps
`default_nettype none
module mosc_ctrl_tb;
  import mosc_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  logic              sys_clk;
  logic              nrst;
  mosc_bus_s         bus;
  logic [DATA_W-1:0] reg_rdata;
  logic              boot_req;
  mosc_trim_s        factory_trim;
  logic              factory_valid;
  logic              periph_clk0_en;
  logic              spread_fabric_in;
  logic              flash_prog_req;
  logic [CODE_W-1:0] osc_code;
  mosc_trim_s        osc_trim;
  logic [DOWN_W-1:0] spread_down;
  logic              prog_clk_en;
  logic              hf_src_ext;
  logic              lf_src_low_speed;
  int                failures;
  int                checks_done;
  logic [DATA_W-1:0] rv;
  mosc_ctrl dut_u (.sys_clk(sys_clk), .nrst(nrst), .bus(bus), .reg_rdata(reg_rdata),
    .boot_req(boot_req), .factory_trim(factory_trim), .factory_valid(factory_valid),
    .periph_clk0_en(periph_clk0_en), .spread_fabric_in(spread_fabric_in),
    .flash_prog_req(flash_prog_req), .osc_code(osc_code), .osc_trim(osc_trim),
    .spread_down(spread_down), .prog_clk_en(prog_clk_en), .hf_src_ext(hf_src_ext),
    .lf_src_low_speed(lf_src_low_speed));
  // ****************************************
  // tasks
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge sys_clk);
    bus.wr <= 1'b0;
    #1;
  endtask : wr
  // read data stands only in the cycle after the strobe edge
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  // one step enable, then read the count and downspread back
  task automatic step(input int exp_cnt, input int units);
    @(posedge sys_clk);
    periph_clk0_en <= 1'b1;
    @(posedge sys_clk);
    periph_clk0_en <= 1'b0;
    rd(OFF_STATUS, rv);
    chk(rv[23:16], exp_cnt[7:0]);
    chk(spread_down, 32'((exp_cnt * units) >> 8));
  endtask : step
  task automatic results();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  // ****************************************
  // watchdog
  // ****************************************
  initial begin
    #200000;
    failures++;
    results();
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    int tri_q[7];
    logic [LFSR_W-1:0] lfsr_m;
    tri_q = '{1, 2, 2, 1, 0, 0, 1};
    failures = 0;
    checks_done = 0;
    nrst = 1'b0;
    bus = '0;
    factory_trim = '{fine: 8'h11, ref_a: 8'h22, ref_b: 8'h33};
    factory_valid = 1'b0;
    periph_clk0_en = 1'b0;
    spread_fabric_in = 1'b0;
    flash_prog_req = 1'b0;
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    #1;
    chk(osc_code, CODE_RST);
    chk(boot_req, 1'b1);
    chk(lf_src_low_speed, 1'b1);
    chk(hf_src_ext, 1'b0);
    @(posedge sys_clk);
    factory_valid <= 1'b1;
    @(posedge sys_clk);
    // a second valid after boot carries other trims and must be ignored
    factory_trim <= '{fine: 8'h44, ref_a: 8'h55, ref_b: 8'h66};
    @(posedge sys_clk);
    factory_valid <= 1'b0;
    #1;
    chk(osc_trim, 24'h112233);
    chk(boot_req, 1'b0);
    rd(OFF_STATUS, rv);
    chk(rv[8:0], 9'h118);
    $display("test reset and boot done");
    // code table samples at three band edges (0x03, 0x25, 0x35), plus an unlisted code
    wr(OFF_CODE, 32'h03);
    rd(OFF_STATUS, rv);
    chk(rv[6:0], 7'h03);
    wr(OFF_CODE, 32'h25);
    rd(OFF_STATUS, rv);
    chk(rv[6:0], 7'h22);
    wr(OFF_CODE, 32'h35);
    chk(osc_code, 6'h35);
    rd(OFF_STATUS, rv);
    chk(rv[6:0], 7'h30);
    wr(OFF_CODE, 32'h0d);
    chk(osc_code, 6'h35);
    rd(OFF_STATUS, rv);
    chk(rv[6:0], 7'h70);
    // lowering loads a short settle count
    wr(OFF_CODE, 32'h19);
    rd(OFF_STATUS, rv);
    chk(rv[7:0], 8'h98);
    repeat (6) @(posedge sys_clk);
    rd(OFF_STATUS, rv);
    chk(rv[7], 1'b0);
    // trim write loads the long settle count
    wr(OFF_FINE, 32'h5a);
    chk(osc_trim.fine, 8'h5a);
    rd(OFF_STATUS, rv);
    chk(rv[7], 1'b1);
    repeat (480) @(posedge sys_clk);
    rd(OFF_STATUS, rv);
    chk(rv[7], 1'b1);
    repeat (20) @(posedge sys_clk);
    rd(OFF_STATUS, rv);
    chk(rv[7], 1'b0);
    // climb with trims first, then high to high by way of 24 MHz
    wr(OFF_FINE, 32'h61);
    wr(OFF_REFA, 32'h62);
    wr(OFF_REFB, 32'h63);
    repeat (500) @(posedge sys_clk);
    wr(OFF_CODE, 32'h35);
    wr(OFF_CODE, 32'h19);
    wr(OFF_FINE, 32'h71);
    wr(OFF_REFA, 32'h72);
    wr(OFF_REFB, 32'h73);
    repeat (500) @(posedge sys_clk);
    wr(OFF_CODE, 32'h30);
    chk(osc_trim, 24'h717273);
    rd(OFF_CODE, rv);
    chk(rv, 32'h30);
    rd(OFF_REFA, rv);
    chk(rv, 32'h72);
    rd(OFF_STATUS, rv);
    chk(rv[7:0], 8'h2b);
    rd(8'h20, rv);
    chk(rv, 32'h0);
    $display("test code and trims done");
    // source select, reserved values ignored
    wr(OFF_SELECT, 32'h1);
    chk(hf_src_ext, 1'b1);
    wr(OFF_SELECT, 32'h5);
    chk(hf_src_ext, 1'b1);
    rd(OFF_SELECT, rv);
    chk(rv, 32'h1);
    wr(OFF_SELECT, 32'h0);
    chk(hf_src_ext, 1'b0);
    @(posedge sys_clk);
    flash_prog_req <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk(prog_clk_en, 1'b1);
    @(posedge sys_clk);
    flash_prog_req <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk(prog_clk_en, 1'b0);
    $display("test select and prog clock done");
    // triangle, limit 2, depth 4 percent
    wr(OFF_SPREAD, 32'h0209);
    repeat (5) @(posedge sys_clk);
    rd(OFF_STATUS, rv);
    chk(rv[23:16], 8'h0);
    for (int i = 0; i < 7; i++) step(tri_q[i], 400);
    wr(OFF_SPREAD, 32'h0208);
    step(0, 400);
    // fabric driven, clamped at the limit
    wr(OFF_SPREAD, 32'h0207);
    @(posedge sys_clk);
    spread_fabric_in <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (int i = 1; i <= 3; i++) step((i > 2) ? 2 : i, 200);
    @(posedge sys_clk);
    spread_fabric_in <= 1'b0;
    repeat (3) @(posedge sys_clk);
    step(1, 200);
    // pseudo-random: bench lfsr, low byte masked by the limit
    // reserved depth half way through must act as 1 percent
    lfsr_m = LFSR_SEED;
    wr(OFF_SPREAD, 32'h0f02);
    for (int i = 0; i < 6; i++) begin
      if (i == 3) begin
        wr(OFF_SPREAD, 32'h0f0e);
      end
      step(int'(lfsr_m[7:0] & 8'h0f), 100);
      lfsr_m = {lfsr_m[14:0], lfsr_m[15] ^ lfsr_m[13] ^ lfsr_m[12] ^ lfsr_m[10]};
    end
    rd(OFF_SPREAD, rv);
    chk(rv, 32'h0f0e);
    $display("test spread done");
    results();
  end
endmodule : mosc_ctrl_tb
`default_nettype wire
